// File: design/pmf_pkg.sv
// Shared constants and types of the power mode and pin float test block.
package pmf_pkg;

    // ========================================================================
    // Clock and timing
    // ========================================================================
    // Period of ref_clk_in in nanoseconds (20 MHz).
    localparam int PMF_CLK_NS = 50;
    // Least oscillator settling wait after powerdown exit, in nanoseconds.
    localparam int PMF_PD_MIN_NS = 1000;
    // Width of the settling wait counter.
    localparam int PMF_WAIT_W = 8;
    // Least settling wait in clock cycles, rounded up.
    localparam logic [PMF_WAIT_W-1:0] PMF_PD_MIN_CYC =
        PMF_WAIT_W'((PMF_PD_MIN_NS + PMF_CLK_NS - 1) / PMF_CLK_NS);

    // ========================================================================
    // Pin widths and reset values
    // ========================================================================
    // Width of the multiplexed address/data pins.
    localparam int PMF_AD_W = 16;
    // Number of synchronised pin inputs.
    localparam int PMF_SYNC_W = 4;
    // Bit positions of the synchronised pin inputs.
    localparam int PMF_SB_RIN_N = 0;
    localparam int PMF_SB_TSEL = 1;
    localparam int PMF_SB_HOLD = 2;
    localparam int PMF_SB_POWERDOWN_DELAY_TIMER_PIN = 3;
    // Synchroniser reset: reset pin seen active, test pin high, no hold.
    localparam logic [PMF_SYNC_W-1:0] PMF_SYNC_RST = 4'h2;

    // ========================================================================
    // Power modes
    // ========================================================================
    // Reported power mode.
    typedef enum logic [1:0] {
        PMF_MODE_ACTIVE,
        PMF_MODE_IDLE,
        PMF_MODE_POWERDOWN
    } pmf_mode_t;

    // Controller states; the wake state is still reported as powerdown.
    typedef enum logic [1:0] {
        PMF_ST_ACTIVE,
        PMF_ST_IDLE,
        PMF_ST_PDOWN,
        PMF_ST_WAKE
    } pmf_st_t;

endpackage : pmf_pkg

// File: design/pmf_sync3.sv
// Three flip-flop pin synchroniser with second and third stage agreement.
`timescale 1ns/1ps
`default_nettype none

module pmf_sync3 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic ref_clk_in,             // System clock.
    input wire logic rst_in,                 // Synchronous reset, high.
    input wire logic [WIDTH-1:0] d_in,       // Asynchronous pin levels.
    output logic [WIDTH-1:0] q_out           // Filtered synchronous levels.
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } pmf_sync_t;

    pmf_sync_t r;
    pmf_sync_t next_r;

    // Shift the chain; a bit changes only pin_float_test_mode stages two and three agree.
    always_comb begin
        next_r = r;
        next_r.s1 = d_in;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.q = (r.s2 & r.s3) | (r.q & (r.s2 | r.s3));
    end

    // Register the state; reset loads the given idle levels everywhere.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            r <= '{RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
        end else begin
            r <= next_r;
        end
    end

    assign q_out = r.q;

endmodule // pmf_sync3
`default_nettype wire

// File: design/pmf_power_ctrl.sv
// Power mode controller with pin float test mode and pin state control.
// Overview of operation
// [RQ1] Exactly one of three modes holds: active, idle or powerdown.
// [RQ2] Active mode leaves every unit clocked with no gating.
// [RQ3] Idle stops execution and bus unit clocks low; peripherals keep running.
// [RQ4] Powerdown stops every internal clock low and turns the oscillator off.
// [RQ5] Powerdown keeps all register contents unchanged until operation resumes.
// [RQ6] Board logic drives the test select pin low while reset is active.
// [RQ7] The test select pin is weakly pulled high during reset.
// [RQ8] Float test mode puts every output and bidirectional pin in high-Z.
// [RQ9] Pins follow their own rules in hold, reset, idle and powerdown.
// [RQ10] Address/data pins float pin_float_test_mode bus hold is acknowledged.
// [RQ11] Address/data pins float for as long as reset lasts.
// [RQ12] Powerdown holds address/data pins at their levels from its entry.
// [RQ13] Address/data inputs are sampled synchronously and level sensitive.
// [RQ14] Reset status output stays active while the reset input is active.
// [RQ15] After powerdown exit, wait on the delay timer pin before resuming.
// [RQ16] Sleep modes start on software request, end on interrupt or reset.
`timescale 1ns/1ps
`default_nettype none

module pmf_power_ctrl (
    input wire logic ref_clk_in,             // System clock, 20 MHz.
    input wire logic rst_in,                 // Synchronous reset, high.
    input wire logic reset_input_n_in,       // Reset pin, active low, async.
    input wire logic sleep_req_in,           // Software sleep request pulse.
    input wire logic sleep_pd_in,            // Sleep picks powerdown if high.
    input wire logic wake_irq_in,            // Enabled interrupt pending.
    input wire logic hold_req_in,            // Bus hold request pin, async.
    input wire logic [15:0] bus_ad_in,       // Bus unit address/data value.
    input wire logic bus_ad_drive_in,        // Bus unit wants to drive pins.
    input wire logic bus_a19_in,             // Bus unit top address bit.
    input wire logic [15:0] ad_in,           // Address/data pin levels.
    output logic [15:0] ad_out,              // Address/data pin drive value.
    output logic ad_oe_n_out,                // Address/data enable, low.
    output logic [15:0] ad_sample_out,       // Sampled address/data input.
    input wire logic test_select_pin_in,     // Test select pin level.
    output logic test_select_pin_out,        // Test select pin drive value.
    output logic test_select_pin_oe_n_out,   // Test select enable, low.
    output logic test_select_pull_out,       // Weak pull-up enable, high.
    input wire logic pd_timer_pin_in,        // Delay timer pin level.
    output logic pd_timer_pin_out,           // Delay timer pin drive value.
    output logic pd_timer_pin_oe_n_out,      // Delay timer enable, low.
    output logic reset_status_out,           // Reset status pin value.
    output logic reset_status_oe_n_out,      // Reset status enable, low.
    output logic hold_ack_out,               // Bus hold acknowledge.
    output logic float_all_out,              // Float every other device pin.
    output logic cpu_clk_en_out,             // Execution and bus clock run.
    output logic periph_clk_en_out,          // Peripheral clocks run.
    output logic osc_en_out,                 // Crystal oscillator enable.
    output var pmf_pkg::pmf_mode_t mode_out  // Present power mode.
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        pmf_pkg::pmf_st_t st;
        logic reset_status;
        logic strap;
        logic float_mode;
        logic hold_ack;
        logic [15:0] ad;
        logic ad_oe_n;
        logic [15:0] ad_sample;
        logic a19;
        logic pd_drive;
        logic [pmf_pkg::PMF_WAIT_W-1:0] wait_cnt;
    } pmf_state_t;

    localparam pmf_state_t RST = '{
        st: pmf_pkg::PMF_ST_ACTIVE, reset_status: 1'h1, strap: 1'h1,
        float_mode: 1'h0, hold_ack: 1'h0, ad: 16'h0000, ad_oe_n: 1'h1,
        ad_sample: 16'h0000, a19: 1'h0, pd_drive: 1'h0, wait_cnt: 8'h00};

    pmf_state_t r;
    pmf_state_t next_r;
    logic [pmf_pkg::PMF_SYNC_W-1:0] sync_q;
    logic rin_q;
    logic tsel_q;
    logic hold_q;
    logic powerdown_delay_timer_pin_q;

    // ========================================================================
    // Pin synchronisers
    // ========================================================================
    // Reset, test select, hold and delay timer pins arrive asynchronously.
    pmf_sync3 #(
        .WIDTH(pmf_pkg::PMF_SYNC_W),
        .RESET_VAL(pmf_pkg::PMF_SYNC_RST)
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .d_in({pd_timer_pin_in, hold_req_in, test_select_pin_in,
               reset_input_n_in}),
        .q_out(sync_q)
    );

    // Name the filtered pin levels.
    assign rin_q = sync_q[pmf_pkg::PMF_SB_RIN_N];
    assign tsel_q = sync_q[pmf_pkg::PMF_SB_TSEL];
    assign hold_q = sync_q[pmf_pkg::PMF_SB_HOLD];
    assign powerdown_delay_timer_pin_q = sync_q[pmf_pkg::PMF_SB_POWERDOWN_DELAY_TIMER_PIN];

    // ========================================================================
    // Next state
    // ========================================================================
    // Mode sequencing, strap capture and pin states in one pass.
    always_comb begin
        logic drive;
        logic asleep;
        drive = 1'h0;
        asleep = 1'h0;
        next_r = r;
        // [RQ14] Reset status tracking.
        next_r.reset_status = !rin_q;
        if (!rin_q) begin
            // [RQ6] Strap sampled during reset.
            next_r.strap = tsel_q;
            next_r.float_mode = 1'h0;
            // [RQ16] Reset ends any sleep mode.
            next_r.st = pmf_pkg::PMF_ST_ACTIVE;
            next_r.hold_ack = 1'h0;
            // [RQ11] Float during reset.
            next_r.ad_oe_n = 1'h1;
            next_r.pd_drive = 1'h0;
            next_r.wait_cnt = '0;
        end else begin
            // [RQ8] Float mode chosen at release.
            if (r.reset_status) begin
                next_r.float_mode = !r.strap;
            end
            unique case (r.st)
                pmf_pkg::PMF_ST_ACTIVE: begin
                    // [RQ16] Software sleep request.
                    if (sleep_req_in && !r.hold_ack) begin
                        next_r.st = sleep_pd_in ? pmf_pkg::PMF_ST_PDOWN :
                            pmf_pkg::PMF_ST_IDLE;
                    end
                end
                pmf_pkg::PMF_ST_IDLE: begin
                    // [RQ16] Interrupt wakes idle.
                    if (wake_irq_in) begin
                        next_r.st = pmf_pkg::PMF_ST_ACTIVE;
                    end
                end
                pmf_pkg::PMF_ST_PDOWN: begin
                    next_r.pd_drive = 1'h1;
                    next_r.wait_cnt = '0;
                    if (wake_irq_in) begin
                        next_r.st = pmf_pkg::PMF_ST_WAKE;
                    end
                end
                pmf_pkg::PMF_ST_WAKE: begin
                    // [RQ15] Settle on the timer pin.
                    next_r.pd_drive = 1'h0;
                    if (r.wait_cnt != '1) begin
                        next_r.wait_cnt = r.wait_cnt + 8'h01;
                    end
                    if (r.wait_cnt >= pmf_pkg::PMF_PD_MIN_CYC && !powerdown_delay_timer_pin_q) begin
                        next_r.st = pmf_pkg::PMF_ST_ACTIVE;
                    end
                end
            endcase
            asleep = (r.st == pmf_pkg::PMF_ST_PDOWN) ||
                (r.st == pmf_pkg::PMF_ST_WAKE);
            // [RQ9] Hold is granted outside powerdown only.
            next_r.hold_ack = hold_q && !asleep;
            // [RQ5] Registers held while asleep.
            // [RQ12] Pins keep their state while asleep.
            if (!asleep) begin
                // [RQ10] Hold floats the bus.
                drive = bus_ad_drive_in && !hold_q && !r.hold_ack &&
                    (r.st == pmf_pkg::PMF_ST_ACTIVE);
                next_r.ad_oe_n = !drive;
                next_r.a19 = bus_a19_in;
                if (drive) begin
                    next_r.ad = bus_ad_in;
                end
            end
            // [RQ8] Float test mode overrides all drive.
            if (next_r.float_mode) begin
                next_r.ad_oe_n = 1'h1;
            end
        end
        // [RQ13] Level sampling in the active state while pins act as inputs.
        if (r.ad_oe_n && r.st == pmf_pkg::PMF_ST_ACTIVE) begin
            next_r.ad_sample = ad_in;
        end
    end

    // Register the state; reset loads the idle values.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            r <= RST;
        end else begin
            r <= next_r;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    // Address/data, test select and delay timer pin drivers.
    assign ad_out = r.ad;
    assign ad_oe_n_out = r.ad_oe_n;
    assign ad_sample_out = r.ad_sample;
    assign test_select_pin_out = r.a19;
    assign test_select_pin_oe_n_out = r.reset_status || r.float_mode ||
        r.hold_ack;
    // [RQ7] Weak pull-up during reset.
    assign test_select_pull_out = r.reset_status;
    assign pd_timer_pin_out = 1'h1;
    assign pd_timer_pin_oe_n_out = !r.pd_drive || r.float_mode;
    assign reset_status_out = r.reset_status;
    assign reset_status_oe_n_out = r.float_mode;
    assign hold_ack_out = r.hold_ack;
    assign float_all_out = r.float_mode;

    // Clock gating per mode; the oscillator restarts on wake.
    // [RQ2] Clock enables per mode.
    assign cpu_clk_en_out = (r.st == pmf_pkg::PMF_ST_ACTIVE);
    // [RQ3] Peripherals run in idle.
    assign periph_clk_en_out = (r.st == pmf_pkg::PMF_ST_ACTIVE) ||
        (r.st == pmf_pkg::PMF_ST_IDLE);
    // [RQ4] Oscillator off in powerdown.
    assign osc_en_out = (r.st != pmf_pkg::PMF_ST_PDOWN);

    // Reported mode; the settling wait still counts as powerdown.
    // [RQ1] One mode at a time.
    always_comb begin
        unique case (r.st)
            pmf_pkg::PMF_ST_ACTIVE: mode_out = pmf_pkg::PMF_MODE_ACTIVE;
            pmf_pkg::PMF_ST_IDLE: mode_out = pmf_pkg::PMF_MODE_IDLE;
            pmf_pkg::PMF_ST_PDOWN: mode_out = pmf_pkg::PMF_MODE_POWERDOWN;
            pmf_pkg::PMF_ST_WAKE: mode_out = pmf_pkg::PMF_MODE_POWERDOWN;
        endcase
    end

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    a_mode_exclusive: assert property ( // RQ1
        $onehot({mode_out == pmf_pkg::PMF_MODE_ACTIVE,
                 mode_out == pmf_pkg::PMF_MODE_IDLE,
                 mode_out == pmf_pkg::PMF_MODE_POWERDOWN}))
        else $error("Power mode is not exactly one of three.");
    a_active_clocks: assert property ( // RQ2
        mode_out == pmf_pkg::PMF_MODE_ACTIVE |-> cpu_clk_en_out &&
        periph_clk_en_out && osc_en_out)
        else $error("Active mode gates a clock.");
    a_idle_gating: assert property ( // RQ3
        mode_out == pmf_pkg::PMF_MODE_IDLE |-> !cpu_clk_en_out &&
        periph_clk_en_out)
        else $error("Idle clock gating wrong.");
    a_pdown_clocks: assert property ( // RQ4
        r.st == pmf_pkg::PMF_ST_PDOWN |-> !cpu_clk_en_out &&
        !periph_clk_en_out && !osc_en_out)
        else $error("Powerdown leaves a clock running.");
    a_pdown_keep: assert property ( // RQ12
        r.st == pmf_pkg::PMF_ST_PDOWN && !r.reset_status && rin_q |=>
        $stable(ad_out) && $stable(ad_sample_out))
        else $error("Pins or registers changed in powerdown.");
    a_float_test: assert property ( // RQ8
        float_all_out |-> ad_oe_n_out && test_select_pin_oe_n_out &&
        pd_timer_pin_oe_n_out && reset_status_oe_n_out)
        else $error("A pin drives in float test mode.");
    a_strap_float: assert property ( // RQ6
        r.reset_status && rin_q && !r.strap |=> float_all_out)
        else $error("Float test mode not taken from strap.");
    a_hold_float: assert property ( // RQ10
        hold_ack_out |-> ad_oe_n_out)
        else $error("Address/data driven under bus hold.");
    a_reset_float: assert property ( // RQ11
        reset_status_out |-> ad_oe_n_out && test_select_pull_out &&
        test_select_pin_oe_n_out)
        else $error("Pins wrong during reset.");
    a_reset_status_output_track: assert property ( // RQ14
        !rin_q |=> reset_status_out)
        else $error("Reset status dropped while reset active.");
    a_wake_wait: assert property ( // RQ15
        r.st == pmf_pkg::PMF_ST_WAKE && rin_q &&
        r.wait_cnt < pmf_pkg::PMF_PD_MIN_CYC |=> !cpu_clk_en_out)
        else $error("Resumed before settling wait.");
    a_sleep_cause: assert property ( // RQ16
        $rose(r.st == pmf_pkg::PMF_ST_IDLE) |-> $past(sleep_req_in))
        else $error("Idle entered without request.");
    a_sample_level: assert property ( // RQ13
        !rst_in && r.ad_oe_n && r.st == pmf_pkg::PMF_ST_ACTIVE |=>
        ad_sample_out == $past(ad_in))
        else $error("Address/data input not sampled.");

endmodule // pmf_power_ctrl
`default_nettype wire

// File: bench/pmf_board_model.sv
// Board model: reset strap, delay timer capacitor and pin wire levels.
`timescale 1ns/1ps
`default_nettype none

module pmf_board_model #(
    parameter int DISCH = 8
) (
    input wire logic clk_in,           // System clock.
    input wire logic strap_low_in,     // Board pulls test select low.
    input wire logic [15:0] ad_val_in, // Board value on address/data.
    input wire logic ad_drv_in,        // Board drives address/data.
    input wire logic [15:0] ad_out_in, // Device address/data value.
    input wire logic ad_oe_n_in,       // Device address/data enable.
    input wire logic ts_out_in,        // Device test select value.
    input wire logic ts_oe_n_in,       // Device test select enable.
    input wire logic ts_pull_in,       // Device weak pull-up enable.
    input wire logic pd_out_in,        // Device delay timer value.
    input wire logic pd_oe_n_in,       // Device delay timer enable.
    output logic [15:0] ad_pin_out,    // Address/data wire level.
    output logic ts_pin_out,           // Test select wire level.
    output logic pd_pin_out            // Delay timer wire level.
);
    logic [7:0] cap = 8'h00;

    // Capacitor charge, held full while driven, then drained each cycle.
    // capacitor discharge time
    always @(posedge clk_in) begin
        if (!pd_oe_n_in && pd_out_in) begin
            cap <= 8'(DISCH);
        end else if (cap != 8'h00) begin
            cap <= cap - 8'h01;
        end
    end

    // Wire levels; an undriven address/data or test select line shows the inverse of the device output value; the delay timer line shows the capacitor.
    // strap pulled low by board
    assign ts_pin_out = !ts_oe_n_in ? ts_out_in : strap_low_in ? 1'b0 :
                        ts_pull_in ? 1'b1 : !ts_out_in;
    assign ad_pin_out = !ad_oe_n_in ? ad_out_in : ad_drv_in ? ad_val_in :
                        ~ad_out_in;
    assign pd_pin_out = !pd_oe_n_in ? pd_out_in : (cap != 8'h00);
endmodule // pmf_board_model

`default_nettype wire

// File: bench/power_mode_and_float_test_test.sv
// Self-checking testbench of the power mode and pin float test block.
`timescale 1ns/1ps
`default_nettype none

module power_mode_and_float_test_test;
    logic clk = 1'b0, rst = 1'b1, rin_n = 1'b0, slp = 1'b0, slp_pd = 1'b0;
    logic wake = 1'b0, hold = 1'b0, bdrv = 1'b0, strap = 1'b0, addrv = 1'b0;
    logic a19 = 1'b0;
    logic [15:0] bad = 16'h0000, adv = 16'h0000;
    logic [15:0] ado, smp, adp;
    logic adoe, tso, tsoe, pull, pdo, pdoe, rs, rsoe, ack, flt;
    logic cpu, per, osc, tsp, pdp;
    pmf_pkg::pmf_mode_t mode;
    int fail_count = 0, compares = 0;

    // Clock of 50 ns period.
    always #25 clk = ~clk;

    pmf_power_ctrl u_pmf_power_ctrl (.ref_clk_in(clk), .rst_in(rst),
        .reset_input_n_in(rin_n), .sleep_req_in(slp), .sleep_pd_in(slp_pd),
        .wake_irq_in(wake), .hold_req_in(hold), .bus_ad_in(bad),
        .bus_ad_drive_in(bdrv), .bus_a19_in(a19), .ad_in(adp),
        .ad_out(ado), .ad_oe_n_out(adoe), .ad_sample_out(smp),
        .test_select_pin_in(tsp), .test_select_pin_out(tso),
        .test_select_pin_oe_n_out(tsoe), .test_select_pull_out(pull),
        .pd_timer_pin_in(pdp), .pd_timer_pin_out(pdo),
        .pd_timer_pin_oe_n_out(pdoe), .reset_status_out(rs),
        .reset_status_oe_n_out(rsoe), .hold_ack_out(ack),
        .float_all_out(flt), .cpu_clk_en_out(cpu),
        .periph_clk_en_out(per), .osc_en_out(osc), .mode_out(mode));

    pmf_board_model u_pmf_board_model (.clk_in(clk), .strap_low_in(strap),
        .ad_val_in(adv), .ad_drv_in(addrv), .ad_out_in(ado),
        .ad_oe_n_in(adoe), .ts_out_in(tso), .ts_oe_n_in(tsoe),
        .ts_pull_in(pull), .pd_out_in(pdo), .pd_oe_n_in(pdoe),
        .ad_pin_out(adp), .ts_pin_out(tsp), .pd_pin_out(pdp));

    // Comparison helpers and timing helpers.
    task automatic chkw(input string nm, input logic [15:0] s,
                        input logic [15:0] e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic chk(input string nm, input logic s, input logic e);
        chkw(nm, {15'h0000, s}, {15'h0000, e});
    endtask
    task automatic chm(input pmf_pkg::pmf_mode_t e);
        chkw("mode", 16'(mode), 16'(e));
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic go_sleep(input logic pd);
        @(posedge clk);
        slp <= 1'b1;
        slp_pd <= pd;
        @(posedge clk);
        slp <= 1'b0;
        @(negedge clk);
    endtask
    task automatic pulse_wake();
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        @(negedge clk);
    endtask

    // Pin reset with the strap chosen, then release.
    task automatic pin_reset(input logic s);
        int n;
        @(posedge clk);
        rin_n <= 1'b0;
        strap <= s;
        tick(8);
        chk("reset_status", rs, 1'b1);
        chk("ad_oe_n", adoe, 1'b1);
        chk("pull", pull, 1'b1);
        chm(pmf_pkg::PMF_MODE_ACTIVE);
        @(posedge clk);
        rin_n <= 1'b1;
        n = 0;
        while (rs !== 1'b0 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk("reset_status", rs, 1'b0);
        tick(2);
        @(posedge clk);
        strap <= 1'b0;
        tick(1);
        chk("float", flt, s);
    endtask

    // Idle entry, refused request, interrupt exit.
    task automatic t_idle();
        go_sleep(1'b0);
        chm(pmf_pkg::PMF_MODE_IDLE);
        chk("cpu_clk", cpu, 1'b0);
        chk("periph_clk", per, 1'b1);
        chk("osc", osc, 1'b1);
        go_sleep(1'b1);
        chm(pmf_pkg::PMF_MODE_IDLE);
        pulse_wake();
        chm(pmf_pkg::PMF_MODE_ACTIVE);
        chk("cpu_clk", cpu, 1'b1);
        chk("periph_clk", per, 1'b1);
    endtask

    // Powerdown: clocks off, pins frozen, settling wait.
    task automatic t_pdown();
        int n;
        @(posedge clk);
        bad <= 16'h5a3c;
        bdrv <= 1'b1;
        tick(3);
        go_sleep(1'b1);
        chm(pmf_pkg::PMF_MODE_POWERDOWN);
        chk("cpu_clk", cpu, 1'b0);
        chk("periph_clk", per, 1'b0);
        chk("osc", osc, 1'b0);
        @(posedge clk);
        bad <= 16'hc3a5;
        tick(4);
        chkw("ad_out", ado, 16'h5a3c);
        chk("ad_oe_n", adoe, 1'b0);
        chk("pd_timer_oe_n", pdoe, 1'b0);
        chk("pd_timer", pdo, 1'b1);
        pulse_wake();
        n = 0;
        while (mode !== pmf_pkg::PMF_MODE_ACTIVE && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk("pd_wait", n >= 20 && n < 200, 1'b1);
        chk("pd_timer_oe_n", pdoe, 1'b1);
        chkw("ad_out", ado, 16'h5a3c);
        tick(2);
        chkw("ad_out", ado, 16'hc3a5);
    endtask

    // Bus hold floats the bus and blocks sleep requests.
    task automatic t_hold();
        int n;
        @(posedge clk);
        hold <= 1'b1;
        a19 <= 1'b1;
        n = 0;
        while (ack !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        chk("hold_ack", ack, 1'b1);
        chk("ad_oe_n", adoe, 1'b1);
        chk("tsel_oe_n", tsoe, 1'b1);
        go_sleep(1'b0);
        chm(pmf_pkg::PMF_MODE_ACTIVE);
        @(posedge clk);
        hold <= 1'b0;
        tick(8);
        chk("hold_ack", ack, 1'b0);
        chk("ad_oe_n", adoe, 1'b0);
        chk("tsel_oe_n", tsoe, 1'b0);
        chk("tsel", tso, 1'b1);
    endtask

    // Address/data inputs sampled while the bus is released.
    task automatic t_sample();
        @(posedge clk);
        bdrv <= 1'b0;
        adv <= 16'h9e61;
        addrv <= 1'b1;
        tick(3);
        chkw("ad_sample", smp, 16'h9e61);
        @(posedge clk);
        adv <= 16'h1f2e;
        tick(2);
        chkw("ad_sample", smp, 16'h1f2e);
        @(posedge clk);
        addrv <= 1'b0;
    endtask

    // Float test chosen from powerdown, then cleared by a new reset.
    task automatic t_float();
        @(posedge clk);
        bdrv <= 1'b1;
        go_sleep(1'b1);
        pin_reset(1'b1);
        chk("ad_oe_n", adoe, 1'b1);
        chk("tsel_oe_n", tsoe, 1'b1);
        chk("rst_stat_oe_n", rsoe, 1'b1);
        chk("pd_timer_oe_n", pdoe, 1'b1);
        pin_reset(1'b0);
        tick(2);
        chk("ad_oe_n", adoe, 1'b0);
    endtask

    // Verdict and end of run.
    task automatic final_report();
        if (fail_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        pin_reset(1'b0);
        t_idle();
        t_pdown();
        t_hold();
        t_sample();
        t_float();
        final_report();
    end

    // Watchdog against a hang.
    initial begin
        #(50 * 20000);
        fail_count++;
        final_report();
    end
endmodule // power_mode_and_float_test_test

`default_nettype wire
